// [verilog/csrps_params.svh]
`ifndef CSRPS_PARAMS_SVH
`define CSRPS_PARAMS_SVH

// data and index widths
`define CSRPS_DW            16
`define CSRPS_IDX_W         2
`define CSRPS_FLAG_W        7
`define CSRPS_TMR_W         10

// reset values
`define CSRPS_IDX_RST       2'h0
`define CSRPS_FLAG_RST      7'h00
`define CSRPS_WORD_RST      16'h0000

// index of the main register
`define CSRPS_IDX_MAIN      2'h0

// main_status_control bit positions
`define CSRPS_B_ERR         15
`define CSRPS_B_FLAG_HI     14
`define CSRPS_B_FLAG_LO     8
`define CSRPS_B_IRQ         7
`define CSRPS_B_ALLOW       6
`define CSRPS_B_RECEIVER_ACTIVE        5
`define CSRPS_B_TRANSMITTER_ACTIVE        4
`define CSRPS_B_POLL        3
`define CSRPS_B_STOP        2

// positions inside the seven-bit flag vector (bits 14..8)
`define CSRPS_F_OVERLEN     6
`define CSRPS_F_HEARTBEAT   5
`define CSRPS_F_LOST        4
`define CSRPS_F_TIMEOUT     3
`define CSRPS_F_RXDONE      2
`define CSRPS_F_TXDONE      1
`define CSRPS_F_SETUP       0

// flags feeding the error summary and the interrupt flag
`define CSRPS_ERR_MASK      7'h78
`define CSRPS_IRQ_MASK      7'h5f

// timing, figures in ns
`define CSRPS_CLK_NS        40
`define CSRPS_HB_NS         2000
`define CSRPS_BTO_NS        25600
`define CSRPS_HB_CYC        (`CSRPS_HB_NS / `CSRPS_CLK_NS)
`define CSRPS_BTO_CYC       (`CSRPS_BTO_NS / `CSRPS_CLK_NS)

`endif

// [verilog/csrps_pkg.sv]
`default_nettype none
package csrps_pkg;

    // host pins that are synchronised
    typedef struct packed {
        logic cs_n;
        logic port_sel;
        logic read;
        logic strobe_n;
    } csrps_hpin_t;

    // events from the rest of the controller, same clock
    typedef struct packed {
        logic tx_overlength;
        logic lost_frame;
        logic rx_done;
        logic tx_done;
        logic setup_done;
        logic tx_underflow;
        logic tx_chain_fault;
        logic tx_complete;
        logic master_addr;
        logic master_ready;
    } csrps_evt_t;

    // slave access sequencer
    typedef enum logic [1:0] {
        CSRPS_IDLE = 2'b00,
        CSRPS_HOLD = 2'b01
    } csrps_state_t;

endpackage : csrps_pkg
`default_nettype wire

// [verilog/csrps_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module csrps_sync (
    input  wire logic clk,    // device clock
    input  wire logic rst,    // async reset
    input  wire logic pin_i,  // raw pin
    input  wire logic rst_v,  // level held in reset
    output var  logic sync_o  // filtered level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_q;

    // stages hold the pin relative to its idle level, so reset reads idle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q   <= 1'b0;
            s2_q   <= 1'b0;
            s3_q   <= 1'b0;
            lvl_q  <= 1'b0;
        end else begin
            s1_q <= pin_i ^ rst_v;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                lvl_q <= s3_q;
            end
        end
    end

    assign sync_o = lvl_q ^ rst_v;
endmodule : csrps_sync
`default_nettype wire

// [verilog/csrps_wdog.sv]
`timescale 1ns/1ps
`default_nettype none
`include "csrps_params.svh"
module csrps_wdog #(
    parameter logic [`CSRPS_TMR_W-1:0] CYC = 10'd50  // window in cycles
) (
    input  wire logic clk,      // device clock
    input  wire logic rst,      // async reset
    input  wire logic clr,      // stop control, aborts the window
    input  wire logic arm,      // opens the window
    input  wire logic done,     // awaited answer
    output var  logic expire_o  // one-cycle pulse, window ran out
);
    logic [`CSRPS_TMR_W-1:0] cnt_q;
    logic                    busy_q;
    logic                    last;

    assign last = (cnt_q == '0);

    // an answer in the same cycle as the last count still counts as in time
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q    <= '0;
            busy_q   <= 1'b0;
            expire_o <= 1'b0;
        end else begin
            expire_o <= 1'b0;
            if (clr) begin
                busy_q <= 1'b0;
            end else if (arm) begin
                busy_q <= 1'b1;
                cnt_q  <= CYC - 1'b1;
            end else if (busy_q && done) begin
                busy_q <= 1'b0;
            end else if (busy_q && last) begin
                busy_q   <= 1'b0;
                expire_o <= 1'b1;
            end else if (busy_q) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule : csrps_wdog
`default_nettype wire

// [verilog/csrps_top.sv]
// Functional notes
// - port select low reaches the data port, high reaches the index port
// - index low two bits pick register zero to three; upper bits read zero
// - index keeps its last written value until rewritten
// - data port writes and reads the register that the index picks
// - registers one to three only while stopped; else ready, reads zero, no write
// - bit 15 is OR of the four error flags, read only
// - bit 14 set when the transmitter overstays the line
// - bit 13 set when collision fails to show within 2us of transmit end
// - lost frame flag set when a frame is dropped for lack of buffer
// - bit 11 set on bus master ready timeout 25.6us; rx and tx shut off
// - bit 10 set when last receive descriptor of a frame is updated
// - bit 9 set on last transmit descriptor update or transmit failure
// - bit 8 set once the setup block is fetched and stored
// - status flags clear on write of one, reset or stop; zero ignored
// - bit 7 is OR of the interrupt sources, read only
// - interrupt pin low only while bit 6 and bit 7 are both one
// - irq_allow read/write, cleared by reset or stop, not settable stopped
// - receiver_active set on start if enabled and set up, cleared on bus timeout
// - transmitter_active set on start if enabled and set up, cleared on tx faults
// - bit 3 write of one forces a descriptor poll; clears when serviced
// - stop halts activity and clears flags and control bits like a reset; index kept
`timescale 1ns/1ps
`default_nettype none
`include "csrps_params.svh"
module csrps_top
    import csrps_pkg::*;
(
    input  wire logic                   clk,          // 25 MHz clock
    input  wire logic                   rst,          // async bus reset
    // host slave pins
    input  wire logic                   cs_n,         // chip select
    input  wire logic                   port_sel,     // high index, low data
    input  wire logic                   read,         // high for host read
    input  wire logic                   strobe_n,     // data strobe
    input  wire logic [`CSRPS_DW-1:0]   dal_in,       // addr_data_bus in
    output var  logic [`CSRPS_DW-1:0]   dal_out,      // addr_data_bus out
    output var  logic                   dal_oe,       // bus drive enable
    output var  logic                   rdy_n,        // ready to host
    output var  logic                   irq_n,        // interrupt pin
    // controller side
    input  wire logic                   stop_ctrl,    // stop control level
    input  wire logic                   run_request,  // start pulse
    input  wire logic                   rx_disable_cfg, // setup mode bit
    input  wire logic                   tx_disable_cfg, // setup mode bit
    input  wire logic                   collision,    // collision pin
    input  wire csrps_evt_t             evt,          // controller events
    input  wire logic                   poll_ack,     // poll serviced
    output var  logic                   receiver_active, // rx enabled
    output var  logic                   transmitter_active, // tx enabled
    output var  logic                   tx_poll_req,  // fetch descriptor
    // registers one to three, kept elsewhere
    input  wire logic [`CSRPS_DW-1:0]   ext_rdata,    // selected contents
    output var  logic                   ext_wr,       // write pulse
    output var  logic [`CSRPS_IDX_W-1:0] ext_sel,     // register number
    output var  logic [`CSRPS_DW-1:0]   ext_wdata     // write data
);

    // pin synchronisers, one per host control pin
    csrps_hpin_t pin_raw;
    csrps_hpin_t pin_s;
    logic        col_s;

    assign pin_raw = '{cs_n: cs_n, port_sel: port_sel, read: read,
                       strobe_n: strobe_n};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pin
            csrps_sync u_sync (
                .clk    (clk),
                .rst    (rst),
                .pin_i  (pin_raw[gi]),
                .rst_v  (1'b1),
                .sync_o (pin_s[gi])
            );
        end
    endgenerate

    csrps_sync u_col (
        .clk    (clk),
        .rst    (rst),
        .pin_i  (collision),
        .rst_v  (1'b0),
        .sync_o (col_s)
    );

    // timeout watchdogs
    logic hb_expire;
    logic bto_expire;

    // heartbeat window opens when a transmission completes
    csrps_wdog #(
        .CYC (`CSRPS_TMR_W'(`CSRPS_HB_CYC))
    ) u_hb (
        .clk      (clk),
        .rst      (rst),
        .clr      (stop_ctrl),
        .arm      (evt.tx_complete),
        .done     (col_s),
        .expire_o (hb_expire)
    );

    // master ready window opens on each driven address
    csrps_wdog #(
        .CYC (`CSRPS_TMR_W'(`CSRPS_BTO_CYC))
    ) u_bto (
        .clk      (clk),
        .rst      (rst),
        .clr      (stop_ctrl),
        .arm      (evt.master_addr),
        .done     (evt.master_ready),
        .expire_o (bto_expire)
    );

    // register state
    csrps_state_t             state_q;
    csrps_state_t             state_d;
    logic [`CSRPS_IDX_W-1:0]  idx_q;
    logic [`CSRPS_IDX_W-1:0]  idx_d;
    logic [`CSRPS_FLAG_W-1:0] flags_q;
    logic [`CSRPS_FLAG_W-1:0] flags_d;
    logic                     allow_q;
    logic                     allow_d;
    logic                     receiver_active_d;
    logic                     transmitter_active_d;
    logic                     poll_d;
    logic                     setup_ok_q;
    logic                     setup_ok_d;

    // host access decode
    // an access opens when both select and strobe have settled low;
    // data pins are sampled then, having been stable for four cycles
    logic acc_go;
    logic acc_end;
    logic hit_index;
    logic hit_data;
    logic hit_main;
    logic hit_ext;
    logic ext_ok;
    logic wr_index;
    logic wr_main;
    logic wr_ext;

    assign acc_go    = (state_q == CSRPS_IDLE) && !pin_s.cs_n
                       && !pin_s.strobe_n;
    assign acc_end   = pin_s.cs_n || pin_s.strobe_n;
    assign hit_index = acc_go && pin_s.port_sel;
    assign hit_data  = acc_go && !pin_s.port_sel;
    assign hit_main  = hit_data && (idx_q == `CSRPS_IDX_MAIN);
    assign hit_ext   = hit_data && (idx_q != `CSRPS_IDX_MAIN);
    assign ext_ok    = stop_ctrl;
    assign wr_index  = hit_index && !pin_s.read;
    assign wr_main   = hit_main && !pin_s.read;
    assign wr_ext    = hit_ext && !pin_s.read && ext_ok;

    // derived status bits
    logic err_sum;
    logic irq_flag;
    logic [`CSRPS_FLAG_W-1:0] flag_set;
    logic [`CSRPS_FLAG_W-1:0] flag_clr;

    assign err_sum  = |(flags_q & `CSRPS_ERR_MASK);
    assign irq_flag = |(flags_q & `CSRPS_IRQ_MASK);

    // event positions follow the bit order 14 down to 8
    assign flag_set[`CSRPS_F_OVERLEN]   = evt.tx_overlength;
    assign flag_set[`CSRPS_F_HEARTBEAT] = hb_expire;
    assign flag_set[`CSRPS_F_LOST]      = evt.lost_frame;
    assign flag_set[`CSRPS_F_TIMEOUT]   = bto_expire;
    assign flag_set[`CSRPS_F_RXDONE]    = evt.rx_done;
    assign flag_set[`CSRPS_F_TXDONE]    = evt.tx_done;
    assign flag_set[`CSRPS_F_SETUP]     = evt.setup_done;

    // write of one clears, zero leaves alone
    assign flag_clr = wr_main ? dal_in[`CSRPS_B_FLAG_HI:`CSRPS_B_FLAG_LO]
                              : `CSRPS_FLAG_RST;

    // main_status_control read image
    logic [`CSRPS_DW-1:0] main_word;

    always_comb begin
        main_word = `CSRPS_WORD_RST;
        main_word[`CSRPS_B_ERR] = err_sum;
        main_word[`CSRPS_B_FLAG_HI:`CSRPS_B_FLAG_LO] = flags_q;
        main_word[`CSRPS_B_IRQ]   = irq_flag;
        main_word[`CSRPS_B_ALLOW] = allow_q;
        main_word[`CSRPS_B_RECEIVER_ACTIVE]  = receiver_active;
        main_word[`CSRPS_B_TRANSMITTER_ACTIVE]  = transmitter_active;
        main_word[`CSRPS_B_POLL]  = tx_poll_req;
        main_word[`CSRPS_B_STOP]  = stop_ctrl;
    end

    // read data selection
    logic [`CSRPS_DW-1:0] idx_word;
    logic [`CSRPS_DW-1:0] rd_word;

    assign idx_word = {{(`CSRPS_DW-`CSRPS_IDX_W){1'b0}}, idx_q};

    // registers one to three read zero while running: the value is
    // undefined to the host, and zero leaks nothing
    assign rd_word = hit_index ? idx_word :
                     hit_main  ? main_word :
                     ext_ok    ? ext_rdata : `CSRPS_WORD_RST;

    // next-state for index, flags and control bits
    always_comb begin
        idx_d = idx_q;
        if (wr_index) begin
            idx_d = dal_in[`CSRPS_IDX_W-1:0];
        end
    end

    // set wins over a clear landing in the same cycle
    generate
        for (gi = 0; gi < `CSRPS_FLAG_W; gi++) begin : g_flag
            assign flags_d[gi] = stop_ctrl ? 1'b0 :
                (flags_q[gi] & ~flag_clr[gi]) | flag_set[gi];
        end
    endgenerate

    always_comb begin
        allow_d = allow_q;
        if (stop_ctrl) begin
            allow_d = 1'b0;
        end else if (wr_main) begin
            allow_d = dal_in[`CSRPS_B_ALLOW];
        end
    end

    // setup counts as complete once its fetch has finished
    always_comb begin
        setup_ok_d = setup_ok_q;
        if (stop_ctrl) begin
            setup_ok_d = 1'b0;
        end else if (evt.setup_done) begin
            setup_ok_d = 1'b1;
        end
    end

    always_comb begin
        receiver_active_d = receiver_active;
        if (stop_ctrl || bto_expire) begin
            receiver_active_d = 1'b0;
        end else if (evt.setup_done && rx_disable_cfg) begin
            receiver_active_d = 1'b0;
        end else if (run_request && !rx_disable_cfg && setup_ok_q) begin
            receiver_active_d = 1'b1;
        end
    end

    always_comb begin
        transmitter_active_d = transmitter_active;
        if (stop_ctrl || bto_expire) begin
            transmitter_active_d = 1'b0;
        end else if (evt.tx_underflow || evt.tx_chain_fault) begin
            transmitter_active_d = 1'b0;
        end else if (evt.setup_done && tx_disable_cfg) begin
            transmitter_active_d = 1'b0;
        end else if (run_request && !tx_disable_cfg && setup_ok_q) begin
            transmitter_active_d = 1'b1;
        end
    end

    // a fresh demand beats a service acknowledge in the same cycle
    always_comb begin
        poll_d = tx_poll_req;
        if (stop_ctrl) begin
            poll_d = 1'b0;
        end else if (wr_main && dal_in[`CSRPS_B_POLL]) begin
            poll_d = 1'b1;
        end else if (poll_ack) begin
            poll_d = 1'b0;
        end
    end

    // access sequencer: answer once, then wait for strobe release
    always_comb begin
        state_d = state_q;
        case (state_q)
            CSRPS_IDLE: begin
                if (acc_go) begin
                    state_d = CSRPS_HOLD;
                end
            end
            CSRPS_HOLD: begin
                if (acc_end) begin
                    state_d = CSRPS_IDLE;
                end
            end
            default: begin
                state_d = CSRPS_IDLE;
            end
        endcase
    end

    // control and status flops; stop clears all but the index like reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idx_q              <= `CSRPS_IDX_RST;
            flags_q            <= `CSRPS_FLAG_RST;
            allow_q            <= 1'b0;
            setup_ok_q         <= 1'b0;
            receiver_active    <= 1'b0;
            transmitter_active <= 1'b0;
            tx_poll_req        <= 1'b0;
        end else begin
            idx_q              <= idx_d;
            flags_q            <= flags_d;
            allow_q            <= allow_d;
            setup_ok_q         <= setup_ok_d;
            receiver_active    <= receiver_active_d;
            transmitter_active <= transmitter_active_d;
            tx_poll_req        <= poll_d;
        end
    end

    // pin is registered from the next-state flags, so it changes in the same cycle as them
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_n <= 1'b1;
        end else begin
            irq_n <= ~(allow_d & (|(flags_d & `CSRPS_IRQ_MASK)));
        end
    end

    // host bus answer; ready is given even for refused accesses
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= CSRPS_IDLE;
            dal_out <= `CSRPS_WORD_RST;
            dal_oe  <= 1'b0;
            rdy_n   <= 1'b1;
        end else begin
            state_q <= state_d;
            if (acc_go) begin
                dal_out <= rd_word;
                dal_oe  <= pin_s.read;
                rdy_n   <= 1'b0;
            end else if (state_q == CSRPS_HOLD && acc_end) begin
                dal_oe  <= 1'b0;
                rdy_n   <= 1'b1;
            end
        end
    end

    // write strobe toward registers one to three
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_wr    <= 1'b0;
            ext_sel   <= `CSRPS_IDX_RST;
            ext_wdata <= `CSRPS_WORD_RST;
        end else begin
            ext_wr <= wr_ext;
            if (wr_ext) begin
                ext_sel   <= idx_q;
                ext_wdata <= dal_in;
            end
        end
    end

endmodule : csrps_top
`default_nettype wire

// [verification/csrps_checker.sv]
`timescale 1ns/1ps
`default_nettype none
`include "csrps_params.svh"
module csrps_checker
    import csrps_pkg::*;
(
    input wire logic                    clk,                // device clock
    input wire logic                    rst,                // async reset
    input wire logic                    rdy_n,              // ready to host
    input wire logic                    dal_oe,             // bus drive
    input wire logic                    irq_n,              // interrupt pin
    input wire logic                    stop_ctrl,          // stop level
    input wire logic                    run_request,        // start pulse
    input wire csrps_evt_t              evt,                // events
    input wire logic                    poll_ack,           // poll serviced
    input wire logic                    receiver_active,    // rx enabled
    input wire logic                    transmitter_active, // tx enabled
    input wire logic                    tx_poll_req,        // poll request
    input wire logic                    ext_wr,             // ext write
    input wire logic [`CSRPS_IDX_W-1:0] ext_sel             // ext register
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // events that feed the interrupt flag directly
    wire logic src_any = evt.tx_overlength | evt.lost_frame | evt.rx_done
                       | evt.tx_done | evt.setup_done;
    sequence s_ack;
        tx_poll_req && poll_ack;
    endsequence
    sequence s_stop;
        stop_ctrl;
    endsequence
    chk_oe_in_ready: assert property (dal_oe |-> !rdy_n)
        else $error("drive enable outside ready");
    chk_stop_clears_act: assert property (s_stop |=> !receiver_active
        && !transmitter_active && !tx_poll_req)
        else $error("stop left an active bit");
    chk_stop_irq_high: assert property (s_stop |=> irq_n)
        else $error("interrupt pin low after stop");
    chk_ext_wr_gate: assert property (ext_wr |-> ext_sel != 2'h0
        && $past(stop_ctrl))
        else $error("outer register written while running");
    chk_poll_clears: assert property (s_ack |=> !tx_poll_req
        || $fell(rdy_n))
        else $error("poll request outlived its service");
    chk_rx_on_start: assert property ($rose(receiver_active)
        |-> $past(run_request))
        else $error("receiver turned on without start");
    chk_tx_on_start: assert property ($rose(transmitter_active)
        |-> $past(run_request))
        else $error("transmitter turned on without start");
    chk_irq_fall_src: assert property ($fell(irq_n)
        |-> $past(src_any) || $fell(rdy_n))
        else $error("interrupt pin fell without a cause");
endmodule : csrps_checker
bind csrps_top csrps_checker u_chk (.clk(clk), .rst(rst), .rdy_n(rdy_n),
    .dal_oe(dal_oe), .irq_n(irq_n), .stop_ctrl(stop_ctrl), .evt(evt),
    .run_request(run_request), .poll_ack(poll_ack), .ext_wr(ext_wr),
    .receiver_active(receiver_active), .ext_sel(ext_sel),
    .transmitter_active(transmitter_active), .tx_poll_req(tx_poll_req));
`default_nettype wire

// [verification/csrps_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
`include "csrps_params.svh"
module csrps_host_model (
    input  wire logic                 clk,      // device clock
    input  wire logic                 rdy_n,    // ready from device
    input  wire logic [`CSRPS_DW-1:0] dal_out,  // read data
    output var  logic                 cs_n,     // chip select
    output var  logic                 port_sel, // high index, low data
    output var  logic                 read,     // high for read
    output var  logic                 strobe_n, // data strobe
    output var  logic [`CSRPS_DW-1:0] dal_in    // write data
);
    // idle pins; released data shows the inverse, never a stale copy
    initial begin
        cs_n = 1'b1;
        strobe_n = 1'b1;
        port_sel = 1'b0;
        read = 1'b1;
        dal_in = 16'h0000;
    end
    // one slave access; everything held until ready is seen at a rise, or for 20 rises at most
    task automatic xfer(input logic sel, input logic rd,
                        input logic [`CSRPS_DW-1:0] wd,
                        output logic [`CSRPS_DW-1:0] rv);
        int   n;
        logic got;
        got = 1'b0;
        rv = 16'hdead;
        @(negedge clk);
        port_sel = sel;
        read = rd;
        dal_in = wd;
        cs_n = 1'b0;
        strobe_n = 1'b0;
        for (n = 0; n < 20 && !got; n++) begin
            @(posedge clk);
            if (rdy_n === 1'b0) begin
                got = 1'b1;
                rv = dal_out;
            end
        end
        @(negedge clk);
        cs_n = 1'b1;
        strobe_n = 1'b1;
        dal_in = ~wd;
        for (n = 0; n < 20 && rdy_n !== 1'b1; n++)
            @(posedge clk);
        @(posedge clk);
    endtask : xfer
endmodule : csrps_host_model
`default_nettype wire

// [verification/csrps_top_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module csrps_top_bench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        stop_ctrl = 1'b1;
    logic        run_request = 1'b0;
    logic        collision = 1'b0;
    logic        poll_ack = 1'b0;
    logic        dis_cfg = 1'b0;
    logic [9:0]  evt_v = 10'h000;
    logic        cs_n, port_sel, read, strobe_n, dal_oe, rdy_n, irq_n;
    logic        rx_act, tx_act, poll_req, ext_wr;
    logic [1:0]  ext_sel, wsel;
    logic [15:0] dal_in, dal_out, ext_wdata, wdat, v;
    int          err_count = 0;
    int          checks_done = 0;
    int          wr_seen = 0;
    always #20 clk = ~clk;
    csrps_host_model host (.clk(clk), .rdy_n(rdy_n), .dal_out(dal_out),
        .cs_n(cs_n), .port_sel(port_sel), .read(read),
        .strobe_n(strobe_n), .dal_in(dal_in));
    csrps_top dut (.clk(clk), .rst(rst), .cs_n(cs_n), .port_sel(port_sel),
        .read(read), .strobe_n(strobe_n), .dal_in(dal_in),
        .dal_out(dal_out), .dal_oe(dal_oe), .rdy_n(rdy_n), .irq_n(irq_n),
        .stop_ctrl(stop_ctrl), .run_request(run_request),
        .rx_disable_cfg(dis_cfg), .tx_disable_cfg(dis_cfg),
        .collision(collision), .evt(evt_v), .poll_ack(poll_ack),
        .receiver_active(rx_act), .transmitter_active(tx_act),
        .tx_poll_req(poll_req), .ext_rdata(16'ha5c3), .ext_wr(ext_wr),
        .ext_sel(ext_sel), .ext_wdata(ext_wdata));
    // capture writes that leave for the outer registers
    always @(posedge clk) if (ext_wr) begin
        wr_seen <= wr_seen + 1;
        wsel <= ext_sel;
        wdat <= ext_wdata;
    end
    task automatic chk(input string nm, input logic [15:0] ex, got);
        checks_done++;
        if (got !== ex) begin
            err_count++;
            $display("unexpected %s exp %h got %h", nm, ex, got);
        end
    endtask : chk
    task automatic wr(input logic sel, input logic [15:0] d);
        host.xfer(sel, 1'b0, d, v);
    endtask : wr
    task automatic rdc(input logic sel, input logic [15:0] ex);
        host.xfer(sel, 1'b1, 16'h0000, v);
        chk(sel ? "index" : "data", ex, v);
    endtask : rdc
    // event struct bits: overlength 9, lost 8, rx 7, tx 6, setup 5
    task automatic pulse(input logic [9:0] e);
        @(negedge clk);
        evt_v = e;
        @(negedge clk);
        evt_v = 10'h000;
    endtask : pulse
    task automatic start_pulse();
        @(negedge clk);
        run_request = 1'b1;
        @(negedge clk);
        run_request = 1'b0;
    endtask : start_pulse
    task automatic t_ports();
        int n0;
        rdc(1'b1, 16'h0000);
        rdc(1'b0, 16'h0004);
        wr(1'b1, 16'hfff3);
        rdc(1'b1, 16'h0003);
        wr(1'b0, 16'h1234);
        chk("ext sel", 16'h0003, {14'h0, wsel});
        chk("ext data", 16'h1234, wdat);
        rdc(1'b0, 16'ha5c3);
        @(negedge clk) stop_ctrl = 1'b0;
        n0 = wr_seen;
        wr(1'b0, 16'h5678);
        chk("ext writes", 16'(n0), 16'(wr_seen));
        rdc(1'b0, 16'h0000);
        wr(1'b1, 16'h0000);
        $display("test ports done");
    endtask : t_ports
    task automatic t_flags();
        logic [9:0]  ev [4] = '{10'h200, 10'h100, 10'h080, 10'h040};
        logic [15:0] ex [4] = '{16'hc0f0, 16'h90f0, 16'h04f0, 16'h02f0};
        pulse(10'h020);
        start_pulse();
        rdc(1'b0, 16'h01b0);
        wr(1'b0, 16'h0040);
        chk("irq pin on", 16'h0000, {15'h0, irq_n});
        wr(1'b0, 16'h0140);
        chk("irq pin off", 16'h0001, {15'h0, irq_n});
        rdc(1'b0, 16'h0070);
        for (int i = 0; i < 4; i++) begin
            pulse(ev[i]);
            chk("irq pin", 16'h0000, {15'h0, irq_n});
            rdc(1'b0, ex[i]);
            wr(1'b0, 16'h0040);
            rdc(1'b0, ex[i]);
            wr(1'b0, (ex[i] & 16'h7f00) | 16'h0040);
            rdc(1'b0, 16'h0070);
        end
        $display("test flags done");
    endtask : t_flags
    task automatic t_heartbeat();
        pulse(10'h004);
        repeat (70) @(posedge clk);
        rdc(1'b0, 16'ha070);
        wr(1'b0, 16'h2040);
        pulse(10'h004);
        @(negedge clk) collision = 1'b1;
        repeat (70) @(posedge clk);
        @(negedge clk) collision = 1'b0;
        rdc(1'b0, 16'h0070);
        $display("test heartbeat done");
    endtask : t_heartbeat
    task automatic t_timeout();
        wr(1'b0, 16'h0000);
        pulse(10'h002);
        repeat (700) @(posedge clk);
        rdc(1'b0, 16'h8880);
        wr(1'b0, 16'h0800);
        wr(1'b0, 16'h0008);
        chk("poll req", 16'h0001, {15'h0, poll_req});
        @(negedge clk) poll_ack = 1'b1;
        @(negedge clk) poll_ack = 1'b0;
        chk("poll done", 16'h0000, {15'h0, poll_req});
        $display("test timeout and poll done");
    endtask : t_timeout
    task automatic t_stop();
        start_pulse();
        chk("rx on", 16'h0001, {15'h0, rx_act});
        dis_cfg = 1'b1;
        pulse(10'h020);
        chk("disabled", 16'h0000, {14'h0, rx_act, tx_act});
        start_pulse();
        chk("start refused", 16'h0000, {14'h0, rx_act, tx_act});
        @(negedge clk) stop_ctrl = 1'b1;
        repeat (2) @(negedge clk);
        chk("actives", 16'h0000, {14'h0, rx_act, tx_act});
        rdc(1'b0, 16'h0004);
        $display("test stop done");
    endtask : t_stop
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test
    // a hung handshake would stall the whole sequence
    initial begin
        #(40 * 8000);
        err_count++;
        $display("watchdog expired");
        finish_test();
    end
    initial begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (6) @(negedge clk);
        t_ports();
        t_flags();
        t_heartbeat();
        t_timeout();
        t_stop();
        finish_test();
    end
endmodule : csrps_top_bench
`default_nettype wire
